// >>> src/msd_period_cnt.sv
// Period counter of prescaled reference ticks between tachometer edges
`timescale 1ns/1ps
module msd_period_cnt
	import msd_pkg::*;
#(
	parameter int unsigned W = CNT_W
) (
	input  wire logic         i_clk,    // System clock
	input  wire logic         i_rst_n,  // Async reset, active low
	input  wire logic         i_clr,    // Hold counter at zero
	input  wire logic         i_tick,   // Prescaled tick
	input  wire logic         i_edge,   // Tach edge: capture and restart
	output logic [W-1:0]      o_count,  // Count captured at last edge
	output logic              o_valid   // One-cycle pulse with new count
);
	initial begin
		if (W < 12) $error("W too narrow for target count");
	end

	logic [W-1:0] cnt;
	logic [W-1:0] next_cnt;
	logic [W-1:0] next_count;
	logic         next_valid;

	// ----------------------------------------
	// Counting and capture; saturates so a stalled motor reads as very slow
	// ----------------------------------------
	always_comb begin
		next_cnt   = cnt;
		next_count = o_count;
		next_valid = 1'b0;
		if (i_clr) begin
			next_cnt = '0;
		end else if (i_edge) begin
			next_count = cnt;
			next_valid = 1'b1;
			// A tick on the edge cycle opens the new period, so no tick is lost to either period
			next_cnt   = i_tick ? W'(1) : '0;
		end else if (i_tick && cnt != '1) begin
			next_cnt = cnt + W'(1);
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt     <= '0;
			o_count <= '0;
			o_valid <= 1'b0;
		end else begin
			cnt     <= next_cnt;
			o_count <= next_count;
			o_valid <= next_valid;
		end
	end
endmodule

// >>> src/msd_pkg.sv
// Package of constants and carrier types for the motor speed discriminator
package msd_pkg;
	// ----------------------------------------
	// Timing and counting constants
	// ----------------------------------------
	localparam int unsigned CLK_HZ          = 10_000_000;     // System clock rate
	localparam int unsigned PRESCALE        = 8;              // Reference prescaler ratio
	localparam int unsigned TARGET_COUNT    = 2046;           // Prescaled ticks per tach period
	localparam int unsigned LOCK_PERMILLE   = 313;            // 3.13 % in hundredths of percent
	localparam int unsigned LOCK_BAND       = (TARGET_COUNT * LOCK_PERMILLE) / 10000; // Lock band in ticks
	localparam int unsigned CNT_W           = 16;             // Period counter width
	localparam int unsigned STOP_FILT       = 4;              // Low cycles counted before stop; one more low cycle means stop
	localparam int unsigned STOP_FILT_NS    = STOP_FILT * 1_000_000_000 / CLK_HZ; // Stop filter time, ns

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic        RST_LOCK_N      = 1'b1;           // Lock flag released after reset
	localparam logic        RST_DRIVE       = 1'b0;           // Drive outputs off after reset

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {
		MSD_ERR_IDLE,
		MSD_ERR_ACCEL,
		MSD_ERR_DECEL
	} msd_err_t;

	typedef struct packed {
		logic o;       // Level driven while enabled
		logic oe;      // High while the pin is driven
	} msd_pin_t;
endpackage

// >>> src/msd_top.sv
// Speed discriminator, lock detector and start/stop logic of the motor driver
`timescale 1ns/1ps
// Functional notes
// - Target count 2046 ticks per period
// - One error pulse each tachometer cycle, none on exact target
// - Error output high, low or released
// - Reference divided by eight before counting
// - Locked within plus or minus 3.13 percent
// - Lock flag pulled low while locked
// - Low tach input requests stop state
// - Stop turns off drive and regulators
// - Held tach input low gives reset
// - Lock flag released until first pulse
// - Error output low when speed too high
// - One pin carries tach and start/stop
module msd_top
	import msd_pkg::*;
#(
	parameter int unsigned TARGET = TARGET_COUNT,
	parameter int unsigned BAND   = LOCK_BAND,
	parameter int unsigned DIV    = PRESCALE
) (
	input  wire logic I_CLK,                 // Reference clock, 10 MHz
	input  wire logic I_RST_N,               // Async reset, active low
	input  wire logic I_TACH_IN_STARTSTOP,   // Tach pulse; held low means stop
	output logic      O_ERR_O,               // Error output level
	output logic      O_ERR_OE,              // Error output driven when high
	output logic      O_LOCK_FLAG_OUT_OE,    // Open-collector lock flag: high pulls low
	output logic      O_DRIVE_EN,            // Motor drive outputs enabled
	output logic      O_REG_EN               // Bias and 5 V regulators enabled
);
	initial begin
		if (TARGET < 2 || TARGET >= (1 << CNT_W) - 1) $error("TARGET out of range");
		if (BAND >= TARGET) $error("BAND too wide");
		if (DIV < 1 || DIV > 256) $error("DIV out of range");
	end

	// ----------------------------------------
	// Stop detection; a filter keeps low tach phases of up to STOP_FILT cycles from stopping the motor
	// ----------------------------------------
	logic [3:0] stop_run;
	logic [3:0] next_stop_run;
	logic       stopped;
	logic       next_stopped;
	logic       tach_d;
	logic       seen_pulse;
	logic       next_seen_pulse;
	logic       tach_rise;
	logic       period_vld;       // New period result from the counter below

	assign tach_rise = I_TACH_IN_STARTSTOP && !tach_d;

	always_comb begin
		next_stop_run   = stop_run;
		next_stopped    = stopped;
		next_seen_pulse = seen_pulse;
		if (I_TACH_IN_STARTSTOP) begin
			next_stop_run = '0;
			next_stopped  = 1'b0;
		end else if (stop_run != 4'(STOP_FILT)) begin
			next_stop_run = stop_run + 4'h1;
		end else begin
			next_stopped = 1'b1;
		end
		// Set by the first result after start; that result is partial and is not used
		if (stopped) begin
			next_seen_pulse = 1'b0;
		end else if (period_vld) begin
			next_seen_pulse = 1'b1;
		end
	end

	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			stop_run   <= '0;
			stopped    <= 1'b1;
			tach_d     <= 1'b0;
			seen_pulse <= 1'b0;
		end else begin
			stop_run   <= next_stop_run;
			stopped    <= next_stopped;
			tach_d     <= I_TACH_IN_STARTSTOP;
			seen_pulse <= next_seen_pulse;
		end
	end

	// ----------------------------------------
	// Reference prescaler
	// ----------------------------------------
	logic [7:0] pre;
	logic [7:0] next_pre;
	logic       tick;
	logic       next_tick;

	always_comb begin
		next_tick = 1'b0;
		next_pre  = pre + 8'h01;
		if (stopped || pre == 8'(DIV - 1)) begin
			next_pre  = '0;
			next_tick = !stopped;
		end
	end

	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			pre  <= '0;
			tick <= 1'b0;
		end else begin
			pre  <= next_pre;
			tick <= next_tick;
		end
	end

	// ----------------------------------------
	// Period measurement
	// ----------------------------------------
	logic [CNT_W-1:0] period;

	msd_period_cnt #(
		.W       (CNT_W)
	) u_period (
		.i_clk   (I_CLK),
		.i_rst_n (I_RST_N),
		.i_clr   (stopped),
		.i_tick  (tick),
		.i_edge  (tach_rise),
		.o_count (period),
		.o_valid (period_vld)
	);

	// ----------------------------------------
	// Charge-pump error pulse; the first period after start is discarded as partial
	// ----------------------------------------
	msd_err_t         err_st;
	msd_err_t         next_err_st;
	logic [CNT_W-1:0] err_len;
	logic [CNT_W-1:0] next_err_len;
	logic             lock;
	logic             next_lock;
	logic [CNT_W-1:0] diff;
	logic             slow;

	always_comb begin
		slow = period > CNT_W'(TARGET);
		diff = slow ? period - CNT_W'(TARGET) : CNT_W'(TARGET) - period;
		next_err_st  = err_st;
		next_err_len = err_len;
		next_lock    = lock;
		if (stopped) begin
			next_err_st  = MSD_ERR_IDLE;
			next_err_len = '0;
			next_lock    = 1'b0;
		end else if (period_vld && seen_pulse) begin
			next_lock = diff <= CNT_W'(BAND);
			if (diff != '0) begin
				next_err_len = diff;
				next_err_st  = slow ? MSD_ERR_ACCEL : MSD_ERR_DECEL;
			end else begin
				next_err_st = MSD_ERR_IDLE;
			end
		end else if (tick && err_st != MSD_ERR_IDLE) begin
			next_err_len = err_len - CNT_W'(1);
			if (err_len == CNT_W'(1)) begin
				next_err_st = MSD_ERR_IDLE;
			end
		end
	end

	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			err_st  <= MSD_ERR_IDLE;
			err_len <= '0;
			lock    <= 1'b0;
		end else begin
			err_st  <= next_err_st;
			err_len <= next_err_len;
			lock    <= next_lock;
		end
	end

	// ----------------------------------------
	// Registered outputs
	// ----------------------------------------
	msd_pin_t next_err_pin;

	always_comb begin
		case (next_err_st)
			MSD_ERR_ACCEL: next_err_pin = '{o: 1'b1, oe: 1'b1};
			MSD_ERR_DECEL: next_err_pin = '{o: 1'b0, oe: 1'b1};
			MSD_ERR_IDLE:  next_err_pin = '{o: 1'b0, oe: 1'b0};
			default:       next_err_pin = '{o: 1'b0, oe: 1'b0};
		endcase
	end

	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			O_ERR_O            <= 1'b0;
			O_ERR_OE           <= 1'b0;
			O_LOCK_FLAG_OUT_OE <= !RST_LOCK_N;
			O_DRIVE_EN         <= RST_DRIVE;
			O_REG_EN           <= RST_DRIVE;
		end else begin
			// Stop entry releases every pin on the same edge, not one cycle late
			O_ERR_O            <= next_err_pin.o && !next_stopped;
			O_ERR_OE           <= next_err_pin.oe && !next_stopped;
			O_LOCK_FLAG_OUT_OE <= next_lock && !next_stopped;
			O_DRIVE_EN         <= !next_stopped;
			O_REG_EN           <= !next_stopped;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	AST_STOP_OFF: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		stopped |-> !O_DRIVE_EN && !O_REG_EN && !O_ERR_OE && !O_LOCK_FLAG_OUT_OE)
		else $error("outputs active in stop");
	AST_STOP_ENTRY: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		!I_TACH_IN_STARTSTOP [*5] |=> stopped)
		else $error("stop not entered");
	AST_START: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		I_TACH_IN_STARTSTOP |=> O_DRIVE_EN)
		else $error("drive not enabled after start");
	AST_DECEL: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		(period_vld && seen_pulse && !stopped && period < CNT_W'(TARGET)) |=> O_ERR_OE && !O_ERR_O)
		else $error("fast motor not decelerated");
	AST_ACCEL: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		(period_vld && seen_pulse && !stopped && period > CNT_W'(TARGET)) |=> O_ERR_OE && O_ERR_O)
		else $error("slow motor not accelerated");
	AST_LOCK: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		(period_vld && seen_pulse && !stopped && diff <= CNT_W'(BAND)) |=> O_LOCK_FLAG_OUT_OE)
		else $error("lock flag not set in band");
	AST_NOLOCK_EARLY: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		!seen_pulse |=> !lock)
		else $error("lock before first pulse");
	logic [8:0] tick_gap;
	logic [8:0] next_tick_gap;
	logic       had_tick;
	logic       next_had_tick;

	// Cycles since the last tick; only the prescaler assertion reads it
	always_comb begin
		next_tick_gap = tick_gap;
		next_had_tick = had_tick;
		if (stopped) begin
			next_tick_gap = '0;
			next_had_tick = 1'b0;
		end else if (tick) begin
			next_tick_gap = 9'h001;
			next_had_tick = 1'b1;
		end else if (tick_gap != '1) begin
			next_tick_gap = tick_gap + 9'h001;
		end
	end

	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			tick_gap <= '0;
			had_tick <= 1'b0;
		end else begin
			tick_gap <= next_tick_gap;
			had_tick <= next_had_tick;
		end
	end

	AST_TICK: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		(tick && had_tick && !stopped) |-> tick_gap == 9'(DIV))
		else $error("prescaler tick spacing wrong");
	AST_EXACT: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		(period_vld && seen_pulse && !stopped && period == CNT_W'(TARGET)) |=> !O_ERR_OE && O_LOCK_FLAG_OUT_OE)
		else $error("exact target not idle");
	COV_ACCEL: cover property (@(posedge I_CLK) O_ERR_OE && O_ERR_O);
	COV_DECEL: cover property (@(posedge I_CLK) O_ERR_OE && !O_ERR_O);
	COV_LOCK:  cover property (@(posedge I_CLK) $rose(O_LOCK_FLAG_OUT_OE));
	COV_STOP:  cover property (@(posedge I_CLK) $fell(O_DRIVE_EN));
endmodule

// >>> tb/msd_tach_model.sv
// Tachometer pulse and start/stop line model for the motor speed discriminator
`timescale 1ns/1ps
module msd_tach_model (
	input  wire logic        i_clk,  // Bench clock
	input  wire logic        i_stop, // Hold the line low to request stop
	input  wire logic [15:0] i_per,  // Tach period in clock cycles
	output logic             o_tach  // Combined tach and start/stop line
);
	logic [15:0] cnt;
	logic [15:0] cur_per;

	initial begin
		cnt = 16'h0000;
		cur_per = 16'h0010;
	end

	// ----------------------------------------
	// Period generator
	// ----------------------------------------
	// Moves on the falling edge so the design always samples a settled line
	always @(negedge i_clk) begin
		if (i_stop) begin
			cnt <= 16'h0000; // Held low means stop and gives the initial reset
			cur_per <= i_per;
		end else if (cnt + 16'h0001 >= cur_per) begin
			cnt <= 16'h0000; // New period starts with a rising edge
			cur_per <= i_per;
		end else begin
			cnt <= cnt + 16'h0001;
		end
	end

	// Two-cycle low phase stays well below the stop filter length
	assign o_tach = !i_stop && (cnt < cur_per - 16'h0002);
endmodule

// >>> tb/tb.sv
// Self-checking testbench of the motor speed discriminator
`timescale 1ns/1ps
module tb;
	localparam int TGT = 20;
	localparam int BND = 2;
	localparam int DV  = 2;

	logic        clk   = 1'b0;
	logic        rst_n = 1'b0;
	logic        stop  = 1'b1;
	logic [15:0] per   = 16'(DV * TGT);
	logic        tach;
	logic        err_o;
	logic        err_oe;
	logic        lock_oe;
	logic        drive_en;
	logic        reg_en;
	int          error_cnt = 0;
	int          samples_checked = 0;
	int          cycles = 0;
	int          corners[7] = '{0, BND, -BND, BND + 1, -BND - 1, 8, -8};

	always #50 clk = ~clk; // Reference for the prescaler

	msd_top #(.TARGET(TGT), .BAND(BND), .DIV(DV)) i_dut (
		.I_CLK(clk), .I_RST_N(rst_n), .I_TACH_IN_STARTSTOP(tach), .O_ERR_O(err_o), .O_ERR_OE(err_oe),
		.O_LOCK_FLAG_OUT_OE(lock_oe), .O_DRIVE_EN(drive_en), .O_REG_EN(reg_en));

	msd_tach_model i_tach (.i_clk(clk), .i_stop(stop), .i_per(per), .o_tach(tach));

	// ----------------------------------------
	// Reporting
	// ----------------------------------------
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// A hang would otherwise never reach the verdict
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			error_cnt++;
			print_verdict();
		end
	end

	task automatic check(input logic got, input logic exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t ns got %h expected %h", $time, got, exp);
		end
	endtask

	// Waits for a rising tach edge as the design samples it, then lets results land.
	// The previous level is taken at a rising edge, so a rise on the calling edge is not counted.
	task automatic wait_edge(input int settle);
		logic prev;
		int   n;
		n = 0;
		@(posedge clk);
		prev = tach;
		@(posedge clk);
		while (!(tach && !prev) && n < 2000) begin
			prev = tach;
			n++;
			@(posedge clk);
		end
		if (n >= 2000) check(1'b0, 1'b1);
		repeat (settle) @(posedge clk);
		@(negedge clk);
	endtask

	// Runs a period of TGT+d ticks; the period between the two edges has the new length.
	// Pins change one edge after the design sees the rise, and a one-tick pulse may last one cycle.
	task automatic run_period(input int d);
		per = 16'(DV * (TGT + d));
		wait_edge(0);
		wait_edge(1);
		check(lock_oe, d <= BND && d >= -BND);
		check(err_oe, d != 0);
		if (d != 0) begin
			check(err_o, d > 0);
			repeat ((d < 0 ? -d : d) * DV + DV) @(negedge clk);
			check(err_oe, 1'b0);
		end
		$display("test period offset %0d done", d);
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		void'($urandom(92));
		repeat (20) @(negedge clk);
		rst_n = 1'b1;
		// Start held off about 5 us after reset
		repeat (50) @(negedge clk);
		check(drive_en, 1'b0);
		check(reg_en, 1'b0);
		stop = 1'b0;
		wait_edge(3);
		check(lock_oe, 1'b0);
		check(err_oe, 1'b0);
		check(drive_en, 1'b1);
		check(reg_en, 1'b1);
		$display("test start done");
		foreach (corners[i]) run_period(corners[i]);
		repeat (12) run_period(int'($urandom_range(16, 0)) - 8);
		stop = 1'b1;
		repeat (10) @(negedge clk);
		check(drive_en, 1'b0);
		check(reg_en, 1'b0);
		check(err_oe, 1'b0);
		check(lock_oe, 1'b0);
		$display("test stop done");
		per = 16'(DV * TGT);
		stop = 1'b0;
		wait_edge(3);
		check(lock_oe, 1'b0);
		check(err_oe, 1'b0);
		run_period(0);
		$display("test restart done");
		print_verdict();
	end
endmodule
